// >>> rtl/apc_aux_pin_controller.sv
`timescale 1ns/1ps
`default_nettype none

module apc_aux_pin_controller #(
	parameter int NUM_PINS = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// operating mode and rate
	input wire logic [2:0] opMode,
	input wire logic dclFast,
	// host register writes
	input wire logic [7:0] hostWrData,
	input wire logic dirWrEn,
	input wire logic outWrEn,
	input wire logic driveWrEn,
	input wire logic funcWrEn,
	input wire logic maskWrEn,
	// host register reads
	input wire logic inputRdEn,
	input wire logic irqRdEn,
	output logic [7:0] pinInputReg,
	output logic [1:0] pinIrqFlagsRd,
	output logic hostIrq,
	// serial bus side signals
	input wire logic gateBitIn,
	input wire logic multiframeTx,
	output logic multiframeRx,
	output logic frameSync,
	output logic [2:0] chanSel,
	output logic chanSelBad,
	output logic [4:0] slotBase,
	// pins
	input wire logic [7:0] auxPinIn,
	output logic [7:0] auxPinOut,
	output logic [7:0] auxPinOe,
	output logic [1:0] pullUpEn
);

	initial begin
		if (NUM_PINS != 8)
			$error("apc_aux_pin_controller: only eight pins served");
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0] pinDirection;
	logic [7:0] pinOutput;
	logic [7:0] pinDriveCfg;
	logic [7:0] pinFunctionCfg;
	logic [1:0] pinIrqMask;
	logic [1:0] pinIrqFlags;
	logic [1:0] prevIrqPin;

	// host writes; reset leaves every pin an input and irqs masked
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinDirection <= apc_pkg::DIR_RESET;
			pinOutput <= apc_pkg::OUT_RESET;
			pinDriveCfg <= apc_pkg::DRIVE_RESET;
			pinFunctionCfg <= apc_pkg::FUNC_RESET;
			pinIrqMask <= apc_pkg::MASK_RESET;
		end else begin
			if (dirWrEn)
				pinDirection <= hostWrData;
			if (outWrEn)
				pinOutput <= hostWrData;
			if (driveWrEn)
				pinDriveCfg <= hostWrData;
			if (funcWrEn)
				pinFunctionCfg <= hostWrData;
			if (maskWrEn)
				pinIrqMask <= hostWrData[1:0];
		end
	end

	// ----------------------------------------------------------------
	// mode decode and function selects
	// ----------------------------------------------------------------
	wire lineCard;
	wire mfOutMode;
	wire pin4Mf;
	wire pin5Timing;
	wire pin7Gate;
	wire timingSrc;
	wire [1:0] trigLevel;
	wire timingSig;
	wire bitClock;

	assign lineCard = (opMode == apc_pkg::MODE_LT_T) ||
		(opMode == apc_pkg::MODE_LT_S) || (opMode == apc_pkg::MODE_NT);
	assign mfOutMode = (opMode == apc_pkg::MODE_TE) ||
		(opMode == apc_pkg::MODE_LT_T);
	assign pin4Mf = pinFunctionCfg[apc_pkg::FN_PIN4_SEL];
	assign pin5Timing = pinFunctionCfg[apc_pkg::FN_PIN5_SEL];
	assign timingSrc = pinFunctionCfg[apc_pkg::FN_TIMING_SRC];
	assign pin7Gate = pinFunctionCfg[apc_pkg::FN_PIN7_SEL];
	assign trigLevel = {pinFunctionCfg[apc_pkg::FN_TRIG_B],
		pinFunctionCfg[apc_pkg::FN_TRIG_A]};
	assign timingSig = timingSrc ? bitClock : frameSync;

	// frame sync and bit clock derived from the data clock
	apc_timing_gen u_timing (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.dclFast(dclFast),
		.frameSync(frameSync),
		.bitClock(bitClock),
		.frameStart()
	);

	// ----------------------------------------------------------------
	// per pin drive
	// ----------------------------------------------------------------
	logic [7:0] effDrive;
	logic [7:0] effValue;
	logic [7:0] effPushPull;

	// which pins drive, with what value and what drive type
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			effDrive[i] = ~pinDirection[i];
			effValue[i] = pinOutput[i];
			effPushPull[i] = pinDriveCfg[i];
		end
		if (lineCard)
			effDrive[2:0] = 3'h0;
		if (pin4Mf) begin
			effDrive[apc_pkg::PIN_MF] = mfOutMode;
			effValue[apc_pkg::PIN_MF] = multiframeTx;
			effPushPull[apc_pkg::PIN_MF] = 1'b1;
		end
		if (pin5Timing) begin
			effDrive[apc_pkg::PIN_TIMING] = 1'b1;
			effValue[apc_pkg::PIN_TIMING] = timingSig;
			effPushPull[apc_pkg::PIN_TIMING] = 1'b1;
		end
		if (pin7Gate) begin
			effDrive[apc_pkg::PIN_IRQ_B] = 1'b1;
			effValue[apc_pkg::PIN_IRQ_B] = gateBitIn;
			effPushPull[apc_pkg::PIN_IRQ_B] = 1'b1;
		end
	end

	// open drain pulls low only, push/pull drives both levels
	assign auxPinOut = effValue & effPushPull;
	assign auxPinOe = effDrive & (effPushPull | ~effValue);
	assign pullUpEn = ~(effDrive[7:6] & effPushPull[7:6]);

	// ----------------------------------------------------------------
	// input capture and channel straps
	// ----------------------------------------------------------------
	function automatic logic [4:0] slot_of(input logic [2:0] chan);
		slot_of = 5'(chan * apc_pkg::CHAN_BYTES);
	endfunction : slot_of

	// pin level is latched on a host read, outputs included
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinInputReg <= 8'h00;
			multiframeRx <= 1'b0;
		end else begin
			if (inputRdEn)
				pinInputReg <= auxPinIn;
			if (pin4Mf && !mfOutMode)
				multiframeRx <= auxPinIn[apc_pkg::PIN_MF];
		end
	end

	// strapped channel select, sampled while in line-card mode
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			chanSel <= 3'h0;
			chanSelBad <= 1'b0;
			slotBase <= 5'h00;
		end else if (lineCard) begin
			chanSel <= auxPinIn[2:0];
			chanSelBad <= !dclFast && (auxPinIn[2:0] > 3'h2);
			slotBase <= slot_of(auxPinIn[2:0]);
		end
	end

	// ----------------------------------------------------------------
	// pin interrupts
	// ----------------------------------------------------------------
	wire [1:0] irqIsInput;
	wire [1:0] irqPin;
	wire [1:0] irqTrig;
	wire [1:0] next_flags;

	assign irqIsInput = pinDirection[7:6] & {~pin7Gate, 1'b1};
	assign irqPin = auxPinIn[7:6];
	// per pin select: level fires while low, edge needs high last cycle
	assign irqTrig = irqIsInput & ~irqPin &
		(trigLevel | prevIrqPin);
	// the set wins over a clear in the same cycle
	assign next_flags = (pinIrqFlags & ~{2{irqRdEn}}) | irqTrig;
	assign hostIrq = |(pinIrqFlags & ~pinIrqMask);

	// flags, read snapshot and edge history
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinIrqFlags <= 2'h0;
			pinIrqFlagsRd <= 2'h0;
			prevIrqPin <= 2'h3;
		end else begin
			pinIrqFlags <= next_flags;
			prevIrqPin <= irqPin;
			if (irqRdEn)
				pinIrqFlagsRd <= pinIrqFlags;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_falling_a;
		irqIsInput[0] && !trigLevel[0] && prevIrqPin[0] && !irqPin[0];
	endsequence

	sequence s_flag_a_set;
		##1 pinIrqFlags[0];
	endsequence

	AST_RESET_INPUTS: assert property (@(posedge ref_clk)
		$rose(reset_n) |-> auxPinOe == 8'h00)
		else $error("pins not inputs after reset");

	AST_LINECARD_IN: assert property (@(posedge ref_clk)
		disable iff (!reset_n) lineCard |-> auxPinOe[2:0] == 3'h0)
		else $error("channel select pin driven");

	AST_CAPTURE: assert property (@(posedge ref_clk)
		disable iff (!reset_n) inputRdEn |=> pinInputReg == $past(auxPinIn))
		else $error("input read did not capture pin level");

	AST_DRIVE_AFTER_WRITE: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		outWrEn && !pinDirection[3] && pinDriveCfg[3] && !dirWrEn
		&& !driveWrEn |=> auxPinOe[3] && auxPinOut[3] == $past(hostWrData[3]))
		else $error("output not driven after write");

	AST_OPEN_DRAIN: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		!pinDirection[3] && !pinDriveCfg[3] |->
		!auxPinOut[3] && auxPinOe[3] == !pinOutput[3])
		else $error("open drain drives high");

	AST_TIMING_PIN: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pin5Timing |-> auxPinOe[5] && auxPinOut[5] == timingSig)
		else $error("timing output missing");

	AST_TIMING_SRC: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pin5Timing && !timingSrc |-> auxPinOut[5] == frameSync)
		else $error("frame sync not on timing pin");

	AST_EDGE_FLAG: assert property (@(posedge ref_clk)
		disable iff (!reset_n) s_falling_a |-> s_flag_a_set)
		else $error("falling edge did not set flag");

	AST_IRQ_MASK: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pinIrqMask == 2'h3 |-> !hostIrq)
		else $error("masked interrupt reached host");

	AST_FLAG_HOLD: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pinIrqFlags[1] && !irqRdEn |=> pinIrqFlags[1])
		else $error("flag lost without read");

	AST_PULLUP: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pinDirection[6] |-> pullUpEn[0])
		else $error("pull-up off on input pin");

	AST_GATE_BIT: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pin7Gate |-> auxPinOe[7] && auxPinOut[7] == gateBitIn)
		else $error("gating bit not on pin 7");

	AST_MF_DIR: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		pin4Mf |-> auxPinOe[4] == mfOutMode)
		else $error("multiframe pin direction wrong");

	AST_CHAN: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		lineCard |=> chanSel == $past(auxPinIn[2:0]))
		else $error("channel select not taken");

	AST_SLOW_RANGE: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		lineCard && !dclFast && auxPinIn[2:0] == 3'h3 |=> chanSelBad)
		else $error("out of range channel not flagged");

endmodule : apc_aux_pin_controller

`default_nettype wire

// >>> rtl/apc_pkg.sv
package apc_pkg;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_TE = 3'h0;
	localparam logic [2:0] MODE_LT_T = 3'h1;
	localparam logic [2:0] MODE_LT_S = 3'h2;
	localparam logic [2:0] MODE_NT = 3'h3;
	localparam logic [2:0] MODE_INT_NT = 3'h4;

	// ----------------------------------------------------------------
	// pin positions and function word fields
	// ----------------------------------------------------------------
	localparam int PIN_MF = 4;
	localparam int PIN_TIMING = 5;
	localparam int PIN_IRQ_A = 6;
	localparam int PIN_IRQ_B = 7;
	localparam int FN_PIN4_SEL = 0;
	localparam int FN_PIN5_SEL = 1;
	localparam int FN_TIMING_SRC = 2;
	localparam int FN_PIN7_SEL = 3;
	localparam int FN_TRIG_A = 4;
	localparam int FN_TRIG_B = 5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] OUT_RESET = 8'hFF;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam logic [1:0] MASK_RESET = 2'h3;

	// ----------------------------------------------------------------
	// serial bus timing
	// ----------------------------------------------------------------
	localparam int REF_CLK_KHZ = 100000;
	localparam int DCL_FAST_KHZ = 4096;
	localparam int DCL_SLOW_KHZ = 1536;
	localparam int DCL_FAST_HALF = REF_CLK_KHZ / (2 * DCL_FAST_KHZ);
	localparam int DCL_SLOW_HALF = REF_CLK_KHZ / (2 * DCL_SLOW_KHZ);
	localparam int CHAN_BITS = 32;
	localparam int CHAN_BYTES = 4;
	localparam int CHANS_FAST = 8;
	localparam int CHANS_SLOW = 3;
	localparam int HALVES_PER_BIT = 4;

endpackage : apc_pkg

// >>> rtl/apc_timing_gen.sv
`timescale 1ns/1ps
`default_nettype none

module apc_timing_gen #(
	parameter int HALF_FAST = apc_pkg::DCL_FAST_HALF,
	parameter int HALF_SLOW = apc_pkg::DCL_SLOW_HALF
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// rate select
	input wire logic dclFast,
	// derived timing
	output logic frameSync,
	output logic bitClock,
	output logic frameStart
);

	localparam int HALF_W = 6;
	localparam int FRAME_W = 11;

	initial begin
		if (HALF_FAST < 1 || HALF_SLOW < 1 || HALF_SLOW >= 2 ** HALF_W)
			$error("apc_timing_gen: bad half period");
	end

	logic [HALF_W-1:0] divCnt;
	logic [FRAME_W-1:0] halfCnt;
	logic [HALF_W-1:0] divLast;
	logic [FRAME_W-1:0] frameLast;
	logic dclTick;

	// divider end and frame length follow the data clock rate
	assign divLast = dclFast ? HALF_W'(HALF_FAST - 1) : HALF_W'(HALF_SLOW - 1);
	assign frameLast = dclFast ?
		FRAME_W'(apc_pkg::CHANS_FAST * apc_pkg::CHAN_BITS
			* apc_pkg::HALVES_PER_BIT - 1) :
		FRAME_W'(apc_pkg::CHANS_SLOW * apc_pkg::CHAN_BITS
			* apc_pkg::HALVES_PER_BIT - 1);
	assign dclTick = (divCnt >= divLast);

	// data clock half period divider and frame counter
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt <= '0;
			halfCnt <= '0;
		end else begin
			divCnt <= dclTick ? '0 : divCnt + 1'b1;
			if (dclTick)
				halfCnt <= (halfCnt >= frameLast) ? '0 : halfCnt + 1'b1;
		end
	end

	// frame sync over the first bit, bit clock at half data clock
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frameSync <= 1'b0;
			bitClock <= 1'b0;
			frameStart <= 1'b0;
		end else begin
			frameSync <= (halfCnt < FRAME_W'(apc_pkg::HALVES_PER_BIT));
			bitClock <= ~halfCnt[1];
			frameStart <= dclTick && (halfCnt >= frameLast);
		end
	end

endmodule : apc_timing_gen

`default_nettype wire

// >>> verif/apc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module apc_board_model (
	// design drive
	input wire logic ref_clk,
	input wire logic [7:0] auxPinOut,
	input wire logic [7:0] auxPinOe,
	input wire logic [1:0] pullUpEn,
	// other board parts
	input wire logic [7:0] extOe,
	input wire logic [7:0] extVal,
	// resolved pin level
	output logic [7:0] auxPinIn
);
	// undriven pins without pull-up wander, so stale values never pass
	logic [7:0] lastLvl = 8'hFF;
	logic [7:0] lowDrv;
	logic [7:0] highDrv;
	logic [7:0] pullMask;
	logic [7:0] floatLvl;

	// a low from any party wins, pull-ups only on pins 6 and 7
	assign lowDrv = (auxPinOe & ~auxPinOut) | (extOe & ~extVal);
	assign highDrv = (auxPinOe & auxPinOut) | (extOe & extVal);
	assign pullMask = {pullUpEn, 6'h00};
	assign floatLvl = pullMask | (~pullMask & ~lastLvl);
	assign auxPinIn = ~lowDrv & (highDrv | floatLvl);

	// remember last level to invert it while floating
	always @(posedge ref_clk) begin
		lastLvl <= auxPinIn;
	end
endmodule : apc_board_model

`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	localparam int W_DIR = 0;
	localparam int W_OUT = 1;
	localparam int W_DRV = 2;
	localparam int W_FN = 3;
	localparam int W_MSK = 4;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] opMode = 3'h0;
	logic dclFast = 1'b1;
	logic [7:0] hostWrData = 8'h00;
	logic [4:0] wrEn = 5'h00;
	logic inputRdEn = 1'b0;
	logic irqRdEn = 1'b0;
	logic gateBitIn = 1'b0;
	logic multiframeTx = 1'b0;
	logic [7:0] extOe = 8'h00;
	logic [7:0] extVal = 8'h00;
	logic [7:0] pinInputReg, auxPinOut, auxPinOe, auxPinIn;
	logic [1:0] pinIrqFlagsRd, pullUpEn;
	logic hostIrq, multiframeRx, frameSync, chanSelBad, bad, seenHigh, prev;
	logic [2:0] chanSel;
	logic [4:0] slotBase;
	int fails = 0;
	int checks_done = 0;
	int toggles;

	// clock generator
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	apc_aux_pin_controller DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.opMode(opMode), .dclFast(dclFast), .hostWrData(hostWrData),
		.dirWrEn(wrEn[0]), .outWrEn(wrEn[1]), .driveWrEn(wrEn[2]),
		.funcWrEn(wrEn[3]), .maskWrEn(wrEn[4]), .inputRdEn(inputRdEn),
		.irqRdEn(irqRdEn), .pinInputReg(pinInputReg),
		.pinIrqFlagsRd(pinIrqFlagsRd), .hostIrq(hostIrq),
		.gateBitIn(gateBitIn), .multiframeTx(multiframeTx),
		.multiframeRx(multiframeRx), .frameSync(frameSync),
		.chanSel(chanSel), .chanSelBad(chanSelBad), .slotBase(slotBase),
		.auxPinIn(auxPinIn), .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
		.pullUpEn(pullUpEn));

	apc_board_model board (.ref_clk(ref_clk), .auxPinOut(auxPinOut),
		.auxPinOe(auxPinOe), .pullUpEn(pullUpEn), .extOe(extOe),
		.extVal(extVal), .auxPinIn(auxPinIn));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	// one-cycle write strobe, then an idle cycle
	task automatic wr(input int idx, input logic [7:0] d);
		wrEn[idx] = 1'b1;
		hostWrData = d;
		step(1);
		wrEn = 5'h00;
		step(1);
	endtask : wr

	task automatic rdIn();
		inputRdEn = 1'b1;
		step(1);
		inputRdEn = 1'b0;
		step(1);
	endtask : rdIn

	task automatic rdIrq();
		irqRdEn = 1'b1;
		step(1);
		irqRdEn = 1'b0;
		step(1);
	endtask : rdIrq

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// hang guard, about 1.5 times the expected run
	initial begin
		#200us;
		fails++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		step(5);
		reset_n = 1'b1;
		step(1);
		chk("oe_rst", auxPinOe, 8'h00);
		chk("pu_rst", {6'h00, pullUpEn}, 8'h03);
		extOe = 8'h40;
		step(2);
		chk("irq_rst", {7'h00, hostIrq}, 8'h00);
		extOe = 8'h00;
		// push/pull outputs
		wr(W_DRV, 8'hFF);
		wr(W_DIR, 8'h00);
		chk("out_rst", auxPinOut, 8'hFF);
		wr(W_OUT, 8'hA5);
		chk("oe_pp", auxPinOe, 8'hFF);
		chk("out_pp", auxPinOut, 8'hA5);
		chk("pu_pp", {6'h00, pullUpEn}, 8'h00);
		rdIn();
		chk("in_pp", pinInputReg, 8'hA5);
		// open drain while another part pulls pin 0 low
		extOe = 8'hFF;
		extVal = 8'hFE;
		wr(W_DRV, 8'h00);
		chk("od_high", auxPinOe & auxPinOut, 8'h00);
		chk("pu_od", {6'h00, pullUpEn}, 8'h03);
		rdIn();
		chk("in_od", pinInputReg, 8'hA4);
		// pins 0-2 roles per mode
		for (int m = 0; m < 5; m++) begin
			opMode = m[2:0];
			step(1);
			// open drain with value A5 only pulls pin 1 low
			chk("oe_ch", {5'h00, auxPinOe[2:0]},
				(m >= 1 && m <= 3) ? 8'h00 : 8'h02);
		end
		// strapped channel at both data clock rates
		opMode = apc_pkg::MODE_LT_T;
		extOe = 8'h07;
		for (int c = 0; c < 16; c++) begin
			dclFast = (c < 8);
			extVal[2:0] = c[2:0];
			step(2);
			chk("chan", {5'h00, chanSel}, {5'h00, c[2:0]});
			chk("base", {3'h0, slotBase}, {3'h0, c[2:0], 2'h0});
			chk("bad", {7'h00, chanSelBad}, {7'h00, !dclFast && c[2:0] > 3'h2});
		end
		dclFast = 1'b1;
		opMode = apc_pkg::MODE_TE;
		extOe = 8'h00;
		// function overrides on pins 4, 5, 7
		wr(W_DIR, 8'hFF);
		wr(W_FN, 8'h0B);
		for (int g = 0; g < 2; g++) begin
			gateBitIn = g[0];
			multiframeTx = g[0];
			step(1);
			chk("fn_oe", {6'h00, auxPinOe[7], auxPinOe[4]}, 8'h03);
			chk("gate", {7'h00, auxPinOut[7]}, {7'h00, g[0]});
			chk("mtx", {7'h00, auxPinOut[4]}, {7'h00, g[0]});
		end
		bad = 1'b0;
		seenHigh = 1'b0;
		repeat (13000) begin
			step(1);
			if (auxPinOut[5] !== frameSync || auxPinOe[5] !== 1'b1)
				bad = 1'b1;
			if (frameSync === 1'b1)
				seenHigh = 1'b1;
		end
		chk("fb_fs", {6'h00, bad, seenHigh}, 8'h01);
		wr(W_FN, 8'h0F);
		toggles = 0;
		prev = auxPinOut[5];
		repeat (200) begin
			step(1);
			if (auxPinOut[5] !== prev)
				toggles++;
			prev = auxPinOut[5];
		end
		chk("fb_bc", {7'h00, toggles > 2}, 8'h01);
		// multiframe bit as input
		opMode = apc_pkg::MODE_LT_S;
		extOe = 8'h10;
		for (int v = 0; v < 2; v++) begin
			extVal[4] = v[0];
			step(3);
			chk("mrx_oe", {7'h00, auxPinOe[4]}, 8'h00);
			chk("mrx", {7'h00, multiframeRx}, {7'h00, v[0]});
		end
		// pin interrupts: pin 6 edge, pin 7 level
		opMode = apc_pkg::MODE_TE;
		extOe = 8'h00;
		wr(W_FN, 8'h20);
		wr(W_MSK, 8'h00);
		rdIrq();
		extVal = 8'h00;
		extOe = 8'h40;
		step(2);
		chk("irq_e", {7'h00, hostIrq}, 8'h01);
		rdIrq();
		chk("flg_e", {6'h00, pinIrqFlagsRd}, 8'h01);
		chk("clr_e", {7'h00, hostIrq}, 8'h00);
		extOe = 8'hC0;
		step(2);
		rdIrq();
		chk("flg_l", {6'h00, pinIrqFlagsRd}, 8'h02);
		chk("irq_l", {7'h00, hostIrq}, 8'h01);
		// masked trigger sets the flag only
		extOe = 8'h00;
		step(2);
		rdIrq();
		wr(W_MSK, 8'h03);
		extOe = 8'h40;
		step(2);
		chk("irq_m", {7'h00, hostIrq}, 8'h00);
		rdIrq();
		chk("flg_m", {6'h00, pinIrqFlagsRd}, 8'h01);
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
